/* hdl/ext_irq_pkg.sv */
// Constants for the external pin and pin-change interrupt detector
// Notes on behaviour
// - Pin activity triggers even when pins drive outputs
// - Group 2 requests on enabled sources 23..16 toggling
// - Group 1 requests on enabled sources 14..8 toggling
// - Group 0 requests on enabled sources 7..0 toggling
// - Per-group mask selects contributing pins
// - Pin-change detection works without any clock
// - Dedicated pins: low level, any change, falling or rising
// - Level mode requests while pin stays low
// - Edge detection runs on the I/O clock
// - Low level detected without a clock
// - I/O clock stopped in sleep except idle
// - Level gone before start-up end: wake, no interrupt
// - Sense 00 low, 01 change, 10 fall, 11 rise
// - Pulses longer than one clock are caught
// - Flag set on edge, cleared by ack/write, clear in level
// - Request needs own enable and global enable
package ext_irq_pkg;
  localparam int unsigned EXT_PINS     = 2;
  localparam int unsigned PC_SOURCES   = 24;
  localparam int unsigned PC_GROUPS    = 3;
  localparam int unsigned GROUP_W      = 8;
  localparam int unsigned SENSE_W      = 2;
  localparam logic [1:0] SENSE_LOW     = 2'h0;
  localparam logic [1:0] SENSE_CHANGE  = 2'h1;
  localparam logic [1:0] SENSE_FALL    = 2'h2;
  localparam logic [1:0] SENSE_RISE    = 2'h3;
  localparam logic [3:0] SENSE_RESET   = 4'h0;
  localparam logic [7:0] MASK_RESET    = 8'h00;
  localparam logic [7:0] GROUP1_VALID  = 8'h7f;
  localparam logic [1:0] EXT_EN_RESET  = 2'h0;
  localparam logic [2:0] PC_EN_RESET   = 3'h0;
endpackage : ext_irq_pkg

/* hdl/external_pin_interrupt_detect.sv */
// External pin and pin-change interrupt detector top
`timescale 1ns/10ps
module external_pin_interrupt_detect
  import ext_irq_pkg::*;
(
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     resetn,
  // Pin levels, read regardless of direction
  input  wire logic [ext_irq_pkg::EXT_PINS-1:0]   ext_irq_pin,
  input  wire logic [ext_irq_pkg::PC_SOURCES-1:0] pin_change_sources,
  // Configuration
  input  wire logic [3:0]               ext_irq_sense_ctrl,
  input  wire logic [1:0]               ext_irq_enable,
  input  wire logic [7:0]               pin_change_mask_0,
  input  wire logic [7:0]               pin_change_mask_1,
  input  wire logic [7:0]               pin_change_mask_2,
  input  wire logic [2:0]               pin_change_enable,
  input  wire logic                     global_irq_enable,
  // Clock state and flag clearing
  input  wire logic                     io_clk_running,
  input  wire logic                     startup_done,
  input  wire logic [1:0]               ext_flag_clear,
  input  wire logic [2:0]               pc_flag_clear,
  input  wire logic [1:0]               ext_ack,
  input  wire logic [2:0]               pc_ack,
  // Status and requests
  output logic [1:0]                    ext_irq_flag,
  output logic [2:0]                    pin_change_flag,
  output logic [1:0]                    ext_irq_req,
  output logic                          pin_change_group_0,
  output logic                          pin_change_group_1,
  output logic                          pin_change_group_2,
  output logic                          wake_req
);
  import ext_irq_pkg::*;

  typedef enum logic [2:0] {
    WK_AWAKE  = 3'b001,
    WK_START  = 3'b010,
    WK_CHECK  = 3'b100
  } wake_state_t;

  function automatic logic edge_hit(input logic [1:0] sel, input logic cur,
                                    input logic prev);
    case (sel)
      SENSE_CHANGE: edge_hit = cur ^ prev;
      SENSE_FALL:   edge_hit = prev & ~cur;
      SENSE_RISE:   edge_hit = cur & ~prev;
      default:      edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  logic [1:0]  samp1_q;
  logic [1:0]  samp1_d;
  logic [1:0]  samp2_q;
  logic [1:0]  samp2_d;
  logic [1:0]  prev_q;
  logic [1:0]  prev_d;
  logic [1:0]  eflag_q;
  logic [1:0]  eflag_d;
  logic [1:0]  level_mode;
  logic [1:0]  level_low;
  logic [1:0]  level_ok_q;
  logic [1:0]  level_ok_d;
  logic [2:0]  pc_flag;
  logic [2:0]  pc_async;
  logic [2:0]  pc_clr;
  wake_state_t wk_q;
  wake_state_t wk_d;

  // Dedicated pins
  always_comb begin
    samp1_d    = ext_irq_pin;
    samp2_d    = samp1_q;
    prev_d     = samp2_q;
    eflag_d    = eflag_q;
    level_mode = '0;
    level_low  = '0;
    for (int i = 0; i < EXT_PINS; i++) begin
      level_mode[i] = (ext_irq_sense_ctrl[2*i +: 2] == SENSE_LOW);
      level_low[i]  = level_mode[i] & ~ext_irq_pin[i];
      if (ext_flag_clear[i] | ext_ack[i]) begin
        eflag_d[i] = 1'b0;
      end
      // Edges only while the I/O clock runs
      if (io_clk_running &&
          edge_hit(ext_irq_sense_ctrl[2*i +: 2], samp2_q[i], prev_q[i])) begin
        eflag_d[i] = 1'b1;
      end
      if (level_mode[i]) begin
        eflag_d[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      samp1_q <= 2'h3;
      samp2_q <= 2'h3;
      prev_q  <= 2'h3;
      eflag_q <= 2'h0;
    end else begin
      samp1_q <= samp1_d;
      samp2_q <= samp2_d;
      prev_q  <= prev_d;
      eflag_q <= eflag_d;
    end
  end

  // Wake sequencing: level interrupt only if still low after start-up
  always_comb begin
    wk_d       = wk_q;
    level_ok_d = level_ok_q;
    case (wk_q)
      WK_AWAKE: begin
        level_ok_d = level_low;
        if (!io_clk_running) begin
          wk_d = WK_START;
        end
      end
      WK_START: begin
        level_ok_d = 2'h0;
        if (io_clk_running && startup_done) begin
          wk_d = WK_CHECK;
        end
      end
      WK_CHECK: begin
        level_ok_d = level_low;
        wk_d       = WK_AWAKE;
      end
      default: begin
        wk_d       = WK_AWAKE;
        level_ok_d = 2'h0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wk_q       <= WK_AWAKE;
      level_ok_q <= 2'h0;
    end else begin
      wk_q       <= wk_d;
      level_ok_q <= level_ok_d;
    end
  end

  // Pin-change groups
  assign pc_clr = pc_flag_clear | pc_ack;

  pc_group_detect u_grp0 (
    .ref_clk      (ref_clk),
    .resetn       (resetn),
    .pins         (pin_change_sources[7:0]),
    .mask         (pin_change_mask_0),
    .valid        (8'hff),
    .clr          (pc_clr[0]),
    .flag_q       (pc_flag[0]),
    .async_change (pc_async[0])
  );

  pc_group_detect u_grp1 (
    .ref_clk      (ref_clk),
    .resetn       (resetn),
    .pins         (pin_change_sources[15:8]),
    .mask         (pin_change_mask_1),
    .valid        (GROUP1_VALID),
    .clr          (pc_clr[1]),
    .flag_q       (pc_flag[1]),
    .async_change (pc_async[1])
  );

  pc_group_detect u_grp2 (
    .ref_clk      (ref_clk),
    .resetn       (resetn),
    .pins         (pin_change_sources[23:16]),
    .mask         (pin_change_mask_2),
    .valid        (8'hff),
    .clr          (pc_clr[2]),
    .flag_q       (pc_flag[2]),
    .async_change (pc_async[2])
  );

  // Outputs
  assign ext_irq_flag    = eflag_q;
  assign pin_change_flag = pc_flag;

  always_comb begin
    for (int i = 0; i < EXT_PINS; i++) begin
      ext_irq_req[i] = ext_irq_enable[i] & global_irq_enable &
                       (eflag_q[i] | (level_mode[i] & level_ok_q[i] & level_low[i]));
    end
  end

  assign pin_change_group_0 = pc_flag[0] & pin_change_enable[0] & global_irq_enable;
  assign pin_change_group_1 = pc_flag[1] & pin_change_enable[1] & global_irq_enable;
  assign pin_change_group_2 = pc_flag[2] & pin_change_enable[2] & global_irq_enable;

  assign wake_req = |(level_low & ext_irq_enable) |
                    |(pc_async & pin_change_enable);
endmodule : external_pin_interrupt_detect

/* hdl/pc_group_detect.sv */
// One pin-change group: masked toggle detect on sampled and raw pins
`timescale 1ns/10ps
module pc_group_detect (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  // Pins and configuration
  input  wire logic [7:0]         pins,
  input  wire logic [7:0]         mask,
  input  wire logic [7:0]         valid,
  input  wire logic               clr,
  // Results
  output logic                    flag_q,
  output logic                    async_change
);
  logic [7:0] ref_q;
  logic [7:0] ref_d;
  logic       flag_d;
  logic [7:0] en;

  assign en = mask & valid;
  // Clockless: raw pins against last sampled reference
  assign async_change = |((pins ^ ref_q) & en);

  always_comb begin
    ref_d  = pins;
    flag_d = flag_q;
    if (clr) begin
      flag_d = 1'b0;
    end
    if (|((pins ^ ref_q) & en)) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ref_q  <= 8'h00;
      flag_q <= 1'b0;
    end else begin
      ref_q  <= ref_d;
      flag_q <= flag_d;
    end
  end
endmodule : pc_group_detect

/* test/ext_irq_checker.sv */
// Port checker for the pin interrupt detector
`timescale 1ns/10ps
module ext_irq_checker
  import ext_irq_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        resetn,
  // Pins and configuration
  input wire logic [1:0]  ext_irq_pin,
  input wire logic [23:0] pin_change_sources,
  input wire logic [3:0]  ext_irq_sense_ctrl,
  input wire logic [1:0]  ext_irq_enable,
  input wire logic [7:0]  pin_change_mask_0,
  input wire logic [7:0]  pin_change_mask_2,
  input wire logic [2:0]  pin_change_enable,
  input wire logic        global_irq_enable,
  input wire logic        io_clk_running,
  input wire logic        startup_done,
  // Results
  input wire logic [1:0]  ext_irq_flag,
  input wire logic [2:0]  pin_change_flag,
  input wire logic [1:0]  ext_irq_req,
  input wire logic        pin_change_group_0,
  input wire logic        pin_change_group_1,
  input wire logic        pin_change_group_2,
  input wire logic        wake_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  grp_gate_a: assert property ({pin_change_group_2, pin_change_group_1, pin_change_group_0}
    == (pin_change_flag & pin_change_enable & {3{global_irq_enable}})) else $error("group gate");
  pc0_set_a: assert property (|((pin_change_sources[7:0] ^ $past(pin_change_sources[7:0]))
    & pin_change_mask_0) |=> pin_change_flag[0]) else $error("group 0 flag");
  pc2_set_a: assert property (|((pin_change_sources[23:16] ^ $past(pin_change_sources[23:16]))
    & pin_change_mask_2) |=> pin_change_flag[2]) else $error("group 2 flag");
  pc_wake_a: assert property (|((pin_change_sources[7:0] ^ $past(pin_change_sources[7:0]))
    & pin_change_mask_0) && pin_change_enable[0] && global_irq_enable |-> wake_req)
    else $error("change wake");
  level_flag_a: assert property ((ext_irq_sense_ctrl[1:0] == SENSE_LOW)[*2]
    |-> !ext_irq_flag[0]) else $error("level flag");
  fall_flag_a: assert property (ext_irq_sense_ctrl[1:0] == SENSE_FALL && io_clk_running
    && $fell(ext_irq_pin[0]) |-> ##[1:4] (ext_irq_flag[0] || !io_clk_running)) else $error("fall");
  rise_flag_a: assert property (ext_irq_sense_ctrl[3:2] == SENSE_RISE && io_clk_running
    && $rose(ext_irq_pin[1]) |-> ##[1:4] (ext_irq_flag[1] || !io_clk_running)) else $error("rise");
  stop_edge_a: assert property ((!io_clk_running)[*6] |-> !$rose(ext_irq_flag[0]))
    else $error("edge while stopped");
  level_req_a: assert property ((io_clk_running && startup_done && !ext_irq_pin[0]
    && ext_irq_sense_ctrl[1:0] == SENSE_LOW)[*4] ##0 (ext_irq_enable[0] && global_irq_enable)
    |-> ext_irq_req[0]) else $error("level request");
  level_wake_a: assert property (ext_irq_enable[0] && global_irq_enable && !ext_irq_pin[0]
    && ext_irq_sense_ctrl[1:0] == SENSE_LOW |-> wake_req) else $error("level wake");
  grp2_c: cover property ($rose(pin_change_group_2));
  lvl_c: cover property ($rose(ext_irq_req[0]));
  sleep_wake_c: cover property (!io_clk_running && wake_req);
endmodule : ext_irq_checker

/* test/external_pin_interrupt_detect_test.sv */
// Self-checking bench for the pin interrupt detector
`timescale 1ns/10ps
module external_pin_interrupt_detect_test;
  import ext_irq_pkg::*;
  logic ref_clk, resetn, gie, io_run, su_done, g0, g1, g2, wake, hit;
  logic [1:0] e_pin, en, e_clr, e_ack, e_flag, e_req;
  logic [23:0] pc_pin;
  logic [3:0] sense;
  logic [7:0] m0, m1, m2;
  logic [2:0] pc_en, p_clr, p_ack, p_flag;
  logic [10:0] obs, q_m[$], q_e[$];
  logic [1:0] modes [3] = '{SENSE_FALL, SENSE_RISE, SENSE_CHANGE};
  int n_mismatch = 0, compares = 0, b;
  event ev;
  pin_src u_src (.ext_pin(e_pin), .pc_pin(pc_pin));
  external_pin_interrupt_detect i_dut (.ref_clk(ref_clk), .resetn(resetn),
    .ext_irq_pin(e_pin), .pin_change_sources(pc_pin), .ext_irq_sense_ctrl(sense),
    .ext_irq_enable(en), .pin_change_mask_0(m0), .pin_change_mask_1(m1),
    .pin_change_mask_2(m2), .pin_change_enable(pc_en), .global_irq_enable(gie),
    .io_clk_running(io_run), .startup_done(su_done), .ext_flag_clear(e_clr),
    .pc_flag_clear(p_clr), .ext_ack(e_ack), .pc_ack(p_ack), .ext_irq_flag(e_flag),
    .pin_change_flag(p_flag), .ext_irq_req(e_req), .pin_change_group_0(g0),
    .pin_change_group_1(g1), .pin_change_group_2(g2), .wake_req(wake));
  assign obs = {wake, e_req, e_flag, g2, g1, g0, p_flag};
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] obs expected %h seen %h", exp, seen);
    end
  endtask : chk
  task automatic note(input logic [10:0] m, input logic [10:0] e);
    q_m.push_back(m);
    q_e.push_back(e);
    -> ev;
  endtask : note
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  task automatic end_sim;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  initial forever begin
    @ev;
    #1;
    while (q_m.size() > 0) chk(obs & q_m.pop_front(), q_e.pop_front());
  end
  initial begin
    ref_clk = 0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    #10000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    {resetn, gie, io_run, su_done, en, sense, pc_en} = 13'h0f87;
    {m0, m1, m2, e_clr, e_ack, p_clr, p_ack} = 34'h0;
    b = $urandom(32'h0000_2e2f);
    cyc(6);
    resetn = 1;
    cyc(2);
    for (int g = 0; g < 3; g++) begin
      b = $urandom % ((g == 1) ? 7 : 8);
      {m2, m1, m0} = 24'h00_0001 << (g * 8 + b);
      cyc(1);
      u_src.put(e_pin, pc_pin ^ (24'h00_0001 << (g * 8 + (b + 1) % 7)));
      cyc(2);
      note(11'h407, 11'h000);
      cyc(1);
      u_src.put(e_pin, pc_pin ^ {m2, m1, m0});
      note(11'h400, 11'h400);
      cyc(1);
      note(11'h03f, 11'h009 << g);
      cyc(1);
      gie = 0;
      note(11'h03f, 11'h001 << g);
      cyc(1);
      gie = 1;
      {p_ack, p_clr} = 6'h01 << (g + (g == 1 ? 3 : 0));
      cyc(1);
      {p_ack, p_clr} = 6'h00;
      cyc(1);
      note(11'h007, 11'h000);
    end
    {m0, m1, m2} = 24'h00_0000;
    for (int p = 0; p < 2; p++) begin
      foreach (modes[i]) begin
        sense = 4'(modes[i]) << (2 * p);
        cyc(1);
        for (int lv = 0; lv < 2; lv++) begin
          u_src.put(e_pin ^ (2'h1 << p), pc_pin);
          cyc(4);
          hit = modes[i] == SENSE_CHANGE || modes[i] == (lv ? SENSE_RISE : SENSE_FALL);
          note(11'h140 << p, hit ? 11'h140 << p : 11'h000);
          {e_ack, e_clr} = 4'h1 << (p + 2 * lv);
          cyc(1);
          {e_ack, e_clr} = 4'h0;
        end
      end
    end
    {sense, io_run} = 5'h14;
    cyc(1);
    u_src.put(2'h0, pc_pin);
    cyc(6);
    note(11'h0c0, 11'h000);
    u_src.put(2'h3, pc_pin);
    cyc(6);
    {sense, io_run} = 5'h01;
    cyc(4);
    u_src.put(2'h2, pc_pin);
    note(11'h400, 11'h400);
    cyc(5);
    note(11'h140, 11'h100);
    cyc(1);
    u_src.put(2'h3, pc_pin);
    cyc(2);
    note(11'h100, 11'h000);
    for (int hold = 0; hold < 2; hold++) begin
      {io_run, su_done} = 2'h0;
      cyc(2);
      u_src.put(2'h2, pc_pin);
      cyc(2);
      if (hold == 0) u_src.put(2'h3, pc_pin);
      io_run = 1;
      cyc(3);
      su_done = 1;
      cyc(4);
      note(11'h100, hold ? 11'h100 : 11'h000);
      cyc(1);
      u_src.put(2'h3, pc_pin);
      cyc(2);
    end
    end_sim();
  end
endmodule : external_pin_interrupt_detect_test
bind external_pin_interrupt_detect ext_irq_checker u_chk (.*);

/* test/pin_src.sv */
// Model of the outside drivers on the interrupt pins
`timescale 1ns/10ps
module pin_src (
  // Pin levels
  output logic [1:0]  ext_pin,
  output logic [23:0] pc_pin
);
  initial begin
    ext_pin = 2'h3;
    pc_pin = 24'h00_0000;
  end
  // Levels stay until the next call, well past one clock
  task automatic put(input logic [1:0] e, input logic [23:0] p);
    ext_pin = e;
    pc_pin = p;
  endtask : put
endmodule : pin_src
